// ===== piec_pkg.sv
// package with register map, field layout and types of the interrupt and extended control block
package piec_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] EXT_CTRL_TWO_ADDR = 5'h18;
	localparam logic [4:0] INT_MASK_ADDR = 5'h19;
	localparam logic [4:0] INT_STATUS_ADDR = 5'h1A;

	// ----------------------------------------------------------------
	// field positions and widths
	// ----------------------------------------------------------------
	localparam int PIN_ENABLE_BIT = 15;
	localparam int PENDING_BIT = 15;
	localparam int SPEED_CHANGE_BIT = 14;
	localparam int LINK_CHANGE_BIT = 13;
	localparam int DUPLEX_CHANGE_BIT = 12;
	localparam int RESERVED_CAUSE_BIT = 6;
	localparam int DOWNSHIFT_BIT = 2;
	localparam int RX_ERROR_BIT = 0;
	localparam int NUM_CAUSES = 15;
	localparam int EDGE_RATE_LSB = 13;
	localparam int REDUCED_POWER_BIT = 12;
	localparam int PKT_LEN_LSB = 4;
	localparam int CONN_LOOPBACK_BIT = 0;
	localparam int AN_ENABLE_BIT = 12;
	localparam int ADV_LSB = 5;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [2:0] EDGE_RATE_RESET = 3'h0;
	localparam logic [1:0] PKT_LEN_RESET = 2'h0;
	localparam logic [15:0] MASK_RESET = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [NUM_CAUSES-1:0] CAUSE_VALID = 15'h7FBF; // bit 6 always zero
	localparam logic [3:0] ADV_ALL = 4'hF;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		EDGE_PLUS2 = 3'h0,
		EDGE_PLUS3 = 3'h1,
		EDGE_PLUS4 = 3'h2,
		EDGE_SLOWEST = 3'h3,
		EDGE_FASTEST = 3'h4,
		EDGE_MINUS1 = 3'h5,
		EDGE_DEFAULT = 3'h6,
		EDGE_PLUS1 = 3'h7
	} piec_edge_rate_e;

	typedef enum logic [1:0] {
		PKT_NORMAL = 2'h0,
		PKT_JUMBO_9K = 2'h1,
		PKT_JUMBO_12K = 2'h2,
		PKT_RESERVED = 2'h3
	} piec_pkt_len_e;

	// settings driven to the datapath
	typedef struct packed {
		piec_edge_rate_e edge_rate;
		logic reduced_power;
		piec_pkt_len_e pkt_len;
		logic conn_loopback;
	} piec_ctrl_s;

	// register bus request
	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} piec_bus_s;

endpackage : piec_pkg

// ===== piec_properties.sv
// assertions on the ports of the interrupt and extended control block
`timescale 1ns/100ps
module piec_properties (
	input wire logic i_sys_clk, i_srst, i_soft_rst, i_sticky_keep, i_an_enable,
	input wire logic [3:0] i_advertise,
	input wire logic i_rx_err_carrier_ext, i_wr, i_rd, o_management_interrupt_pin,
	input wire logic [14:0] i_events,
	input wire logic [4:0] i_addr,
	input wire logic [15:0] i_wdata, o_rdata,
	input wire piec_pkg::piec_ctrl_s o_ctrl
);
	// decoded accesses
	wire rs = i_rd && i_addr == piec_pkg::INT_STATUS_ADDR;
	wire rm = i_rd && i_addr == piec_pkg::INT_MASK_ADDR;
	wire wm = i_wr && i_addr == piec_pkg::INT_MASK_ADDR;
	wire wc = i_wr && i_addr == piec_pkg::EXT_CTRL_TWO_ADDR;
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000) else $error("read data without read");
	a_read_clears: assert property (rs && i_events == 15'h0000 ##1 i_events == 15'h0000 ##1 rs |=>
		o_rdata == 16'h0000) else $error("status not cleared");
	a_event_kept: assert property (rs && i_events[13] ##1 !rs ##1 rs |=> o_rdata[13]) else $error("event lost");
	a_rsvd_cause: assert property (rs |=> !o_rdata[6]) else $error("reserved cause set");
	a_pend_cause: assert property (rs |=> !o_rdata[15] || o_rdata[14:0] != 15'h0000) else $error("bare pending");
	a_pin_pending: assert property (rs && o_management_interrupt_pin |=> o_rdata[15]) else $error("pin no pend");
	a_pin_gate: assert property (wm && !i_wdata[15] |=> !o_management_interrupt_pin) else $error("pin ungated");
	a_pin_cause: assert property ($rose(o_management_interrupt_pin) |-> $past(wm) || $past(i_events) != 15'h0000)
		else $error("pin without cause");
	a_ctrl_write: assert property (wc |=> o_ctrl == $past({i_wdata[15:12], i_wdata[5:4], i_wdata[0]}))
		else $error("ctrl write wrong");
	a_ctrl_keep: assert property (i_soft_rst && i_sticky_keep && !wc |=> o_ctrl == ($past(o_ctrl) & 7'h7E))
		else $error("ctrl not kept");
	a_ctrl_clear: assert property (i_soft_rst && !i_sticky_keep && !wc |=> o_ctrl == 7'h00)
		else $error("ctrl not cleared");
	a_mask_back: assert property (wm ##1 !(wm || i_soft_rst) ##1 rm |=> o_rdata == $past(i_wdata, 3))
		else $error("mask readback wrong");
	// main scenarios
	cover property (rs && i_events != 15'h0000);
	cover property ($rose(o_management_interrupt_pin));
	cover property (i_soft_rst && i_sticky_keep);
endmodule : piec_properties
bind piec_top piec_properties piec_properties_i (.i_sys_clk, .i_srst, .i_soft_rst, .i_sticky_keep, .i_an_enable,
	.i_advertise, .i_rx_err_carrier_ext, .i_wr, .i_rd, .o_management_interrupt_pin, .i_events, .i_addr, .i_wdata,
	.o_rdata, .o_ctrl);

// ===== piec_top.sv
// interrupt mask, interrupt status and extended control register block of one transceiver port
`timescale 1ns/100ps

// Functional notes
// - mask bit 15 set lets the interrupt pin follow status bit 15.
// - clearing mask bit 15 only blocks the pin; capture continues.
// - a status read clears every status bit that no event sets in the same cycle.
// - status bit 15 is summary pending; bits 14..0 are causes.
// - speed and duplex change causes need autonegotiation enabled.
// - downshift cause needs all four advertisement bits set.
// - receive error cause ignores carrier-extension symbols.
// - status bits 14..0 map fixed causes; bit 6 reads zero.
// - mask bits 14..0 let the matching cause set pending; sticky, reset zero.
// - mask and status work without the interrupt pin.
// - edge-rate field 15:13 selects transmit edge rate.
// - bit 12 enables reduced-power mode, sticky, reset zero.
// - field 5:4 selects maximum packet length; 11 reserved.
// - jumbo limits assume a 100 ppm reference clock.
// - sticky bits survive software reset while sticky-reset enable is set.
module piec_top (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// software reset and sticky-reset enable from the control registers
	input wire logic i_soft_rst,
	input wire logic i_sticky_keep,
	// qualifiers from other registers
	input wire logic i_an_enable,
	input wire logic [3:0] i_advertise,
	input wire logic i_rx_err_carrier_ext,
	// cause events, one-cycle pulses, bit order as the status register
	input wire logic [14:0] i_events,
	// register port
	input wire logic [4:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// settings and interrupt pin
	output piec_pkg::piec_ctrl_s o_ctrl,
	output logic o_management_interrupt_pin
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [15:0] mask;
	logic [15:0] next_mask;
	logic [14:0] cause;
	logic [14:0] next_cause;
	logic pending;
	logic next_pending;
	piec_pkg::piec_ctrl_s ctrl;
	piec_pkg::piec_ctrl_s next_ctrl;
	logic [15:0] next_rdata;
	logic next_irq;
	logic [14:0] qual_events;
	piec_pkg::piec_bus_s bus;

	// decode a register address hit
	function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_addr);
		hit = (a == reg_addr);
	endfunction : hit

	// bundle the register port
	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// ----------------------------------------------------------------
	// event qualification
	// ----------------------------------------------------------------
	// gate causes by their documented conditions
	always_comb begin
		qual_events = i_events & piec_pkg::CAUSE_VALID;
		if (!i_an_enable) begin
			qual_events[piec_pkg::SPEED_CHANGE_BIT] = 1'b0;
			qual_events[piec_pkg::DUPLEX_CHANGE_BIT] = 1'b0;
		end
		if (i_advertise != piec_pkg::ADV_ALL) begin
			qual_events[piec_pkg::DOWNSHIFT_BIT] = 1'b0;
		end
		if (i_rx_err_carrier_ext) begin
			qual_events[piec_pkg::RX_ERROR_BIT] = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// control, mask and status registers
	// ----------------------------------------------------------------
	// next values of the configuration registers
	always_comb begin
		next_mask = mask;
		next_ctrl = ctrl;
		if (i_soft_rst && !i_sticky_keep) begin
			next_mask = piec_pkg::MASK_RESET;
			next_ctrl.edge_rate = piec_pkg::piec_edge_rate_e'(piec_pkg::EDGE_RATE_RESET);
			next_ctrl.reduced_power = 1'b0;
			next_ctrl.pkt_len = piec_pkg::piec_pkt_len_e'(piec_pkg::PKT_LEN_RESET);
		end
		if (i_soft_rst) begin
			next_ctrl.conn_loopback = 1'b0; // not sticky
		end
		if (bus.wr && hit(bus.addr, piec_pkg::INT_MASK_ADDR)) begin
			next_mask = bus.wdata;
		end
		if (bus.wr && hit(bus.addr, piec_pkg::EXT_CTRL_TWO_ADDR)) begin
			next_ctrl.edge_rate = piec_pkg::piec_edge_rate_e'(bus.wdata[piec_pkg::EDGE_RATE_LSB +: 3]);
			next_ctrl.reduced_power = bus.wdata[piec_pkg::REDUCED_POWER_BIT];
			next_ctrl.pkt_len = piec_pkg::piec_pkt_len_e'(bus.wdata[piec_pkg::PKT_LEN_LSB +: 2]);
			next_ctrl.conn_loopback = bus.wdata[piec_pkg::CONN_LOOPBACK_BIT];
		end
	end

	// next status: read clears, new events win over the clear
	always_comb begin
		next_cause = cause;
		next_pending = pending;
		if (bus.rd && hit(bus.addr, piec_pkg::INT_STATUS_ADDR)) begin
			next_cause = '0;
			next_pending = 1'b0;
		end
		next_cause = next_cause | qual_events;
		if ((qual_events & mask[14:0]) != '0) begin
			next_pending = 1'b1;
		end
		next_irq = next_pending && next_mask[piec_pkg::PIN_ENABLE_BIT];
	end

	// read data mux, valid in the cycle after the strobe
	always_comb begin
		next_rdata = 16'h0000;
		if (bus.rd) begin
			unique case (bus.addr)
				piec_pkg::EXT_CTRL_TWO_ADDR: begin
					next_rdata = {ctrl.edge_rate, ctrl.reduced_power, 6'h00, ctrl.pkt_len, 3'h0, ctrl.conn_loopback};
				end
				piec_pkg::INT_MASK_ADDR: begin
					next_rdata = mask;
				end
				piec_pkg::INT_STATUS_ADDR: begin
					next_rdata = {pending, cause};
				end
				default: begin
					next_rdata = 16'h0000;
				end
			endcase
		end
	end

	// register all state
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			mask <= piec_pkg::MASK_RESET;
			cause <= piec_pkg::STATUS_RESET[14:0];
			pending <= 1'b0;
			ctrl <= '{edge_rate: piec_pkg::EDGE_PLUS2, reduced_power: 1'b0, pkt_len: piec_pkg::PKT_NORMAL,
				conn_loopback: 1'b0};
			o_rdata <= 16'h0000;
			o_ctrl <= '{edge_rate: piec_pkg::EDGE_PLUS2, reduced_power: 1'b0, pkt_len: piec_pkg::PKT_NORMAL,
				conn_loopback: 1'b0};
			o_management_interrupt_pin <= 1'b0;
		end else begin
			mask <= next_mask;
			cause <= next_cause;
			pending <= next_pending;
			ctrl <= next_ctrl;
			o_rdata <= next_rdata;
			o_ctrl <= next_ctrl;
			o_management_interrupt_pin <= next_irq;
		end
	end

endmodule : piec_top

// ===== test_piec_top.sv
// self-checking testbench of the interrupt and extended control block
`timescale 1ns/100ps
module test_piec_top;
	localparam logic [4:0] XC = piec_pkg::EXT_CTRL_TWO_ADDR;
	localparam logic [4:0] MK = piec_pkg::INT_MASK_ADDR;
	localparam logic [4:0] ST = piec_pkg::INT_STATUS_ADDR;
	logic i_sys_clk = 1'b0, i_srst = 1'b1, i_soft_rst = 1'b0, i_sticky_keep = 1'b0, i_an_enable = 1'b1;
	logic i_rx_err_carrier_ext = 1'b0, i_wr = 1'b0, i_rd = 1'b0, o_management_interrupt_pin;
	logic [3:0] i_advertise = 4'hF;
	logic [14:0] i_events = 15'h0000;
	logic [4:0] i_addr = 5'h00;
	logic [15:0] i_wdata = 16'h0000, o_rdata;
	piec_pkg::piec_ctrl_s o_ctrl;
	int n_errors = 0;
	int checked = 0;
	piec_top piec_top_i (.i_sys_clk, .i_srst, .i_soft_rst, .i_sticky_keep, .i_an_enable, .i_advertise,
		.i_rx_err_carrier_ext, .i_events, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_ctrl, .o_management_interrupt_pin);
	// 25 MHz clock
	initial forever #20 i_sys_clk = ~i_sys_clk;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge i_sys_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask : rd
	// one event pulse, or a pulse beside a status read
	task automatic ev(input logic [14:0] v, input logic r);
		@(posedge i_sys_clk);
		i_events <= v;
		i_rd <= r;
		i_addr <= ST;
		@(posedge i_sys_clk);
		i_events <= 15'h0000;
		i_rd <= 1'b0;
		#1;
	endtask : ev
	task automatic sr(input logic k);
		@(posedge i_sys_clk);
		i_soft_rst <= 1'b1;
		i_sticky_keep <= k;
		@(posedge i_sys_clk);
		i_soft_rst <= 1'b0;
	endtask : sr
	task automatic complete_run;
		$display("checked %0d n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	// watchdog
	initial begin
		repeat (3000) @(posedge i_sys_clk);
		n_errors++;
		complete_run();
	end
	// test sequence
	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		rd(XC, 16'h0000);
		rd(MK, 16'h0000);
		rd(ST, 16'h0000);
		wr(5'h1B, 16'hFFFF);
		rd(5'h1B, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			wr(XC, {i[2:0], i[0], 6'h3F, i[1:0], 3'h7, i[0]});
			chk({9'h000, o_ctrl}, {9'h000, i[2:0], i[0], i[1:0], i[0]});
		end
		wr(XC, 16'hFFFF);
		rd(XC, 16'hF031);
		wr(MK, 16'h7FFF);
		rd(MK, 16'h7FFF);
		ev(15'h7FFF, 1'b0);
		chk({15'h0000, o_management_interrupt_pin}, 16'h0000);
		rd(ST, 16'hFFBF);
		rd(ST, 16'h0000);
		@(posedge i_sys_clk);
		i_an_enable <= 1'b0;
		i_advertise <= 4'h7;
		i_rx_err_carrier_ext <= 1'b1;
		ev(15'h7FFF, 1'b0);
		rd(ST, 16'hAFBA);
		@(posedge i_sys_clk);
		i_an_enable <= 1'b1;
		i_advertise <= 4'hF;
		i_rx_err_carrier_ext <= 1'b0;
		wr(MK, 16'hFFFF);
		ev(15'h2000, 1'b0);
		chk({15'h0000, o_management_interrupt_pin}, 16'h0001);
		wr(MK, 16'h7FFF);
		chk({15'h0000, o_management_interrupt_pin}, 16'h0000);
		rd(ST, 16'hA000);
		wr(MK, 16'hFFFF);
		ev(15'h2000, 1'b0);
		ev(15'h2000, 1'b1);
		chk(o_rdata, 16'hA000);
		chk({15'h0000, o_management_interrupt_pin}, 16'h0001);
		rd(ST, 16'hA000);
		sr(1'b1);
		rd(XC, 16'hF030);
		rd(MK, 16'hFFFF);
		sr(1'b0);
		rd(XC, 16'h0000);
		rd(MK, 16'h0000);
		complete_run();
	end
endmodule : test_piec_top
